// >>> hw/uep_regs.svh
// Register offsets, field positions, reset values and limits of the endpoint count/type register slice
`ifndef UEP_REGS_SVH
`define UEP_REGS_SVH

// Word addresses on the Avalon-MM slave port (byte address is four times these)
`define UEP_ADDR_EP0_TALLY 4'h0
`define UEP_ADDR_RX_TALLY 4'h1
`define UEP_ADDR_EP0_SPEED 4'h2
`define UEP_ADDR_TX_SETUP 4'h3
`define UEP_ADDR_NAK_TMO 4'h4
`define UEP_ADDR_RDY_CTRL 4'h5
`define UEP_ADDR_INT_STAT 4'h6
`define UEP_ADDR_INT_EN 4'h7
`define UEP_ADDR_INT_CLR 4'h8

// Byte tally field widths
`define UEP_EP0_TALLY_W 7
`define UEP_RX_TALLY_W 13

// Target speed field, bits 7:6 of both type registers
`define UEP_SPEED_MSB 7
`define UEP_SPEED_LSB 6
`define UEP_SPEED_ILLEGAL 2'h0
`define UEP_SPEED_HIGH 2'h1
`define UEP_SPEED_FULL 2'h2
`define UEP_SPEED_LOW 2'h3

// Transfer protocol field bits 5:4, target endpoint field bits 3:0
`define UEP_TRANSFER_PROTOCOL_MSB 5
`define UEP_TRANSFER_PROTOCOL_LSB 4
`define UEP_TEP_MSB 3
`define UEP_TEP_LSB 0
`define UEP_TRANSFER_PROTOCOL_CONTROL 2'h0
`define UEP_TRANSFER_PROTOCOL_ISO 2'h1
`define UEP_TRANSFER_PROTOCOL_BULK 2'h2
`define UEP_TRANSFER_PROTOCOL_INTR 2'h3

// NAK limit field bits 4:0 and its valid range
`define UEP_NAK_MSB 4
`define UEP_NAK_M_MIN 5'h02
`define UEP_NAK_M_MAX 5'h10
`define UEP_NAK_CNT_W 17

// Ready/control register bits (write 1 to clear the ready and halt flags)
`define UEP_RDY_EP0_BIT 0
`define UEP_RDY_RX_BIT 1
`define UEP_RDY_HALT_BIT 2
`define UEP_RDY_EP0_SPD_BAD_BIT 4
`define UEP_RDY_TX_SPD_BAD_BIT 5

// Interrupt status bits
`define UEP_INT_EP0_RDY 0
`define UEP_INT_RX_RDY 1
`define UEP_INT_NAK_TMO 2
`define UEP_INT_N 3

// Reset values
`define UEP_RST_BYTE 8'h00
`define UEP_RST_SPEED 2'h0
`define UEP_RST_NAK 5'h00

`endif

// >>> hw/uep_pkg.sv
// Types shared by the endpoint count/type register slice
package uep_pkg;

  // Bus handshake states
  typedef enum logic [0:0] {BUS_IDLE, BUS_DONE} uep_bus_e;

  // State of the register slice
  typedef struct packed {
    uep_bus_e bus_state;
    logic waitreq;
    logic [31:0] rdata;
    logic [1:0] ep0_speed;
    logic [7:0] tx_setup;
    logic [4:0] nak_m;
    logic ep0_rdy;
    logic rx_rdy;
    logic ep0_halted;
  } uep_main_s;

  // State of the endpoint 0 NAK time-out counter
  typedef struct packed {
    logic active;
    logic [16:0] count;
    logic hit;
  } uep_nak_s;

  // State of the interrupt bank
  typedef struct packed {
    logic [2:0] status;
    logic [2:0] enable;
    logic irq;
  } uep_irq_s;

endpackage : uep_pkg

// >>> hw/uep_nak_timer.sv
// Endpoint 0 NAK time-out counter, counting frames of an unbroken NAK stream
`timescale 1ns/1ps
`include "uep_regs.svh"

module uep_nak_timer (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Control
  input wire logic host_mode,
  input wire logic [4:0] limit_m,
  input wire logic halted,
  // Link events
  input wire logic frame_tick,
  input wire logic nak_seen,
  input wire logic resp_ok,
  // Time-out pulse
  output logic timeout
);

  uep_pkg::uep_nak_s s_reg;
  uep_pkg::uep_nak_s s_next;

  // Limit of 2^(m-1) frames; values above 16 are held at 16
  function automatic logic [16:0] nak_frames(input logic [4:0] m);
    logic [4:0] mm;
    mm = (m > `UEP_NAK_M_MAX) ? `UEP_NAK_M_MAX : m;
    nak_frames = 17'h00001 << (mm - 5'h01);
  endfunction : nak_frames

  // Count frames while NAKs keep coming
  always_comb begin
    s_next = s_reg;
    s_next.hit = 1'b0;
    if (!host_mode || limit_m < `UEP_NAK_M_MIN || halted || resp_ok) begin
      s_next.active = 1'b0;
      s_next.count = '0;
    end else begin
      if (nak_seen) begin
        s_next.active = 1'b1;
      end
      if (frame_tick && (s_reg.active || nak_seen)) begin
        s_next.count = s_reg.count + 17'h00001;
      end
      if (s_reg.count > nak_frames(limit_m)) begin
        s_next.hit = 1'b1;
        s_next.active = 1'b0;
        s_next.count = '0;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign timeout = s_reg.hit;

endmodule : uep_nak_timer

// >>> hw/uep_irq_bank.sv
// Sticky interrupt status with enable and write-one-to-clear, one level output
`timescale 1ns/1ps
`include "uep_regs.svh"

module uep_irq_bank (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Events and software access
  input wire logic [2:0] event_pulse,
  input wire logic [2:0] clear_mask,
  input wire logic enable_we,
  input wire logic [2:0] enable_wdata,
  // Status
  output logic [2:0] status,
  output logic [2:0] enable,
  output logic irq
);

  uep_pkg::uep_irq_s s_reg;
  uep_pkg::uep_irq_s s_next;

  // Set wins over clear; irq follows the next status
  always_comb begin
    s_next = s_reg;
    s_next.status = event_pulse | (s_reg.status & ~clear_mask);
    if (enable_we) begin
      s_next.enable = enable_wdata;
    end
    s_next.irq = |(s_next.status & s_next.enable);
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign status = s_reg.status;
  assign enable = s_reg.enable;
  assign irq = s_reg.irq;

endmodule : uep_irq_bank

// >>> hw/uep_ep_regs.sv
// Endpoint byte tallies, host type registers and endpoint 0 NAK limit behind an Avalon-MM slave
//
// Overview of operation
// - Endpoint 0 received byte count reads in bits 6:0, upper bits zero.
// - Endpoint 0 count tracks the FIFO live; meaningful while its ready flag is set.
// - Receive endpoint packet byte count reads in bits 12:0, bits 15:13 zero.
// - Receive count tracks the FIFO live; valid while the receive ready flag is set.
// - Both type registers hold target speed in bits 7:6; 0 illegal, 1 high, 2 full, 3 low.
// - Transmit protocol bits 5:4: control, isochronous, bulk, interrupt.
// - NAK limit m in bits 4:0 gives a time-out of 2^(m-1) frames, m from 2 to 16.
// - Endpoint 0 halts when NAKs persist past the programmed number of frames.
// - A NAK limit of 0 or 1 switches the time-out off.
// - Packet arrival sets a ready flag and interrupt; software clears the flag later.
//
// The address map and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`include "uep_regs.svh"

// Register map, word addresses on the slave port
//   0 endpoint 0 byte tally, read-only, bits 6:0
//   1 receive endpoint byte tally, read-only, bits 12:0
//   2 endpoint 0 target speed, bits 7:6 writable, the rest zero
//   3 transmit setup: speed 7:6, protocol 5:4, target endpoint 3:0
//   4 endpoint 0 NAK limit, bits 4:0 writable, the rest zero
//   5 ready/control: bit 0 ep0 ready, bit 1 rx ready, bit 2 ep0 halted
//     Write 1 clears each of those; bit 4 ep0 speed illegal, bit 5 tx speed illegal
//   6 interrupt status, read-only: ep0 packet, rx packet, NAK time-out
//   7 interrupt enable, bits 2:0
//   8 interrupt clear, write 1 clears, reads zero
//   Other words read zero and ignore writes
// Every writable register sits in byte lane 0; a write with that lane off does nothing.

module uep_ep_regs #(
  parameter int EP0_CNT_W = `UEP_EP0_TALLY_W,
  parameter int RX_CNT_W = `UEP_RX_TALLY_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // FIFO byte counts from the endpoint FIFOs
  input wire logic [EP0_CNT_W-1:0] ep0_fifo_bytes,
  input wire logic [RX_CNT_W-1:0] rx_fifo_bytes,
  // Packet arrival pulses
  input wire logic ep0_pkt_rx,
  input wire logic rx_pkt_rx,
  // Host link events
  input wire logic host_mode,
  input wire logic frame_tick,
  input wire logic ep0_nak_rx,
  input wire logic ep0_resp_ok,
  // Type outputs to the transaction engine
  output logic [1:0] ep0_speed,
  output logic [1:0] tx_speed,
  output logic [1:0] tx_protocol,
  output logic [3:0] tx_target_ep,
  // Endpoint status
  output logic ep0_rx_packet_ready,
  output logic rx_packet_ready,
  output logic ep0_halted,
  // Interrupt
  output logic irq
);

  // Field widths larger than the printed fields cannot be presented
  if (EP0_CNT_W < 1 || EP0_CNT_W > `UEP_EP0_TALLY_W) begin : g_ep0_w_check
    $error("EP0_CNT_W out of range");
  end
  if (RX_CNT_W < 1 || RX_CNT_W > `UEP_RX_TALLY_W) begin : g_rx_w_check
    $error("RX_CNT_W out of range");
  end
  // Field positions must sit inside the 8-bit register images
  if (`UEP_SPEED_MSB > 7 || `UEP_TRANSFER_PROTOCOL_MSB > 7 || `UEP_NAK_MSB > 7) begin : g_field_check
    $error("field position outside the register byte");
  end

  uep_pkg::uep_main_s s_reg;
  uep_pkg::uep_main_s s_next;

  logic [2:0] int_status;
  logic [2:0] int_enable;
  logic nak_timeout;
  logic wr_go;
  logic wr_lane0;
  logic [2:0] int_clear;
  logic int_en_we;

  // Widen an 8-bit register image to a bus word
  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h000000, b};
  endfunction : byte_word

  // Replace one masked field of a byte
  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] wd,
                                            input logic [7:0] mask);
    merge_byte = (old & ~mask) | (wd & mask);
  endfunction : merge_byte

  // Illegal target speed code in a 2-bit field
  function automatic logic speed_bad(input logic [1:0] code);
    speed_bad = (code == `UEP_SPEED_ILLEGAL);
  endfunction : speed_bad

  // Lane 0 write completing this cycle at one word address
  function automatic logic wr_hit(input logic go, input logic [3:0] a, input logic [3:0] target);
    wr_hit = go && (a == target);
  endfunction : wr_hit

  // A write takes effect in the answer cycle only, lane 0 carries every writable register
  assign wr_go = (s_reg.bus_state == uep_pkg::BUS_DONE) && write;
  assign wr_lane0 = wr_go && byteenable[0];

  // Interrupt clear and enable strobes
  assign int_clear = wr_hit(wr_lane0, address, `UEP_ADDR_INT_CLR) ? writedata[2:0] : 3'h0;
  assign int_en_we = wr_hit(wr_lane0, address, `UEP_ADDR_INT_EN);

  // Endpoint 0 NAK time-out counter
  uep_nak_timer u_nak (
    .ref_clk(ref_clk),
    .srst(srst),
    .host_mode(host_mode),
    .limit_m(s_reg.nak_m),
    .halted(s_reg.ep0_halted),
    .frame_tick(frame_tick),
    .nak_seen(ep0_nak_rx),
    .resp_ok(ep0_resp_ok),
    .timeout(nak_timeout)
  );

  // Sticky interrupt bank
  uep_irq_bank u_irq (
    .ref_clk(ref_clk),
    .srst(srst),
    .event_pulse({nak_timeout, rx_pkt_rx, ep0_pkt_rx}),
    .clear_mask(int_clear),
    .enable_we(int_en_we),
    .enable_wdata(writedata[2:0]),
    .status(int_status),
    .enable(int_enable),
    .irq(irq)
  );

  // Bus handshake, read mux, register writes and flags
  always_comb begin
    logic [31:0] rd;
    logic [7:0] ctrl_img;
    logic clr_ep0;
    logic clr_rx;
    logic clr_halt;
    rd = 32'h00000000;
    ctrl_img = 8'h00;
    clr_ep0 = 1'b0;
    clr_rx = 1'b0;
    clr_halt = 1'b0;
    s_next = s_reg;

    // Live status image of the ready/control register
    ctrl_img[`UEP_RDY_EP0_BIT] = s_reg.ep0_rdy;
    ctrl_img[`UEP_RDY_RX_BIT] = s_reg.rx_rdy;
    ctrl_img[`UEP_RDY_HALT_BIT] = s_reg.ep0_halted;
    ctrl_img[`UEP_RDY_EP0_SPD_BAD_BIT] = speed_bad(s_reg.ep0_speed);
    ctrl_img[`UEP_RDY_TX_SPD_BAD_BIT] = speed_bad(s_reg.tx_setup[`UEP_SPEED_MSB:`UEP_SPEED_LSB]);

    // Read multiplexer, unmapped words read zero
    unique case (address)
      `UEP_ADDR_EP0_TALLY: begin
        rd = 32'(ep0_fifo_bytes);
      end
      `UEP_ADDR_RX_TALLY: begin
        rd = 32'(rx_fifo_bytes);
      end
      `UEP_ADDR_EP0_SPEED: begin
        rd = byte_word({s_reg.ep0_speed, 6'h00});
      end
      `UEP_ADDR_TX_SETUP: begin
        rd = byte_word(s_reg.tx_setup);
      end
      `UEP_ADDR_NAK_TMO: begin
        rd = byte_word({3'h0, s_reg.nak_m});
      end
      `UEP_ADDR_RDY_CTRL: begin
        rd = byte_word(ctrl_img);
      end
      `UEP_ADDR_INT_STAT: begin
        rd = byte_word({5'h00, int_status});
      end
      `UEP_ADDR_INT_EN: begin
        rd = byte_word({5'h00, int_enable});
      end
      default: begin
        rd = 32'h00000000;
      end
    endcase

    // Two-phase handshake: request seen, then answered one cycle later
    unique case (s_reg.bus_state)
      uep_pkg::BUS_IDLE: begin
        s_next.waitreq = 1'b1;
        if (read || write) begin
          s_next.bus_state = uep_pkg::BUS_DONE;
          s_next.waitreq = 1'b0;
          s_next.rdata = read ? rd : 32'h00000000;
        end
      end
      uep_pkg::BUS_DONE: begin
        s_next.bus_state = uep_pkg::BUS_IDLE;
        s_next.waitreq = 1'b1;
      end
    endcase

    // Software register writes; read-only words and reserved bits ignore data
    if (wr_lane0) begin
      unique case (address)
        `UEP_ADDR_EP0_SPEED: begin
          s_next.ep0_speed = writedata[`UEP_SPEED_MSB:`UEP_SPEED_LSB];
        end
        `UEP_ADDR_TX_SETUP: begin
          s_next.tx_setup = merge_byte(s_reg.tx_setup, writedata[7:0], 8'hff);
        end
        `UEP_ADDR_NAK_TMO: begin
          s_next.nak_m = writedata[`UEP_NAK_MSB:0];
        end
        default: begin
          s_next.nak_m = s_reg.nak_m;
        end
      endcase
    end

    // Write-one-to-clear strobes of the ready/control register
    clr_ep0 = wr_hit(wr_lane0, address, `UEP_ADDR_RDY_CTRL) && writedata[`UEP_RDY_EP0_BIT];
    clr_rx = wr_hit(wr_lane0, address, `UEP_ADDR_RDY_CTRL) && writedata[`UEP_RDY_RX_BIT];
    clr_halt = wr_hit(wr_lane0, address, `UEP_ADDR_RDY_CTRL) && writedata[`UEP_RDY_HALT_BIT];

    s_next.ep0_rdy = ep0_pkt_rx | (s_reg.ep0_rdy & ~clr_ep0);
    s_next.rx_rdy = rx_pkt_rx | (s_reg.rx_rdy & ~clr_rx);
    s_next.ep0_halted = nak_timeout | (s_reg.ep0_halted & ~clr_halt);
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.waitreq <= 1'b1;
      s_reg.ep0_speed <= `UEP_RST_SPEED;
      s_reg.tx_setup <= `UEP_RST_BYTE;
      s_reg.nak_m <= `UEP_RST_NAK;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign readdata = s_reg.rdata;
  assign waitrequest = s_reg.waitreq;
  assign ep0_speed = s_reg.ep0_speed;
  assign tx_speed = s_reg.tx_setup[`UEP_SPEED_MSB:`UEP_SPEED_LSB];
  assign tx_protocol = s_reg.tx_setup[`UEP_TRANSFER_PROTOCOL_MSB:`UEP_TRANSFER_PROTOCOL_LSB];
  assign tx_target_ep = s_reg.tx_setup[`UEP_TEP_MSB:`UEP_TEP_LSB];
  assign ep0_rx_packet_ready = s_reg.ep0_rdy;
  assign rx_packet_ready = s_reg.rx_rdy;
  assign ep0_halted = s_reg.ep0_halted;

endmodule : uep_ep_regs

// >>> bench/uep_usb_target.sv
// Behavioural remote target: frame timing and endpoint 0 handshake answers
`timescale 1ns/1ps
module uep_usb_target #(
  parameter int FRAME_CYC = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Answer mode chosen by the bench
  input wire logic nak_mode,
  // Link events towards the slice
  output logic frame_tick,
  output logic ep0_nak_rx,
  output logic ep0_resp_ok
);
  int cyc = 0;
  // Frame counter, restarted by reset
  always @(posedge ref_clk) begin
    cyc <= (srst || cyc == FRAME_CYC - 1) ? 0 : cyc + 1;
  end
  // One pulse per frame, answer given in that frame
  assign frame_tick = !srst && cyc == FRAME_CYC - 1;
  assign ep0_nak_rx = frame_tick && nak_mode;
  assign ep0_resp_ok = frame_tick && !nak_mode;
endmodule : uep_usb_target

// >>> bench/uep_ep_regs_sva.sv
// Bound assertions on the endpoint register slice ports
`timescale 1ns/1ps
`include "uep_regs.svh"
module uep_sva_chk #(
  parameter int EP0_CNT_W = 7
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Register bus
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Endpoint side
  input wire logic [EP0_CNT_W-1:0] ep0_fifo_bytes,
  input wire logic ep0_pkt_rx,
  input wire logic rx_pkt_rx,
  input wire logic [1:0] ep0_speed,
  input wire logic [1:0] tx_speed,
  input wire logic [1:0] tx_protocol,
  input wire logic [3:0] tx_target_ep,
  input wire logic ep0_rx_packet_ready,
  input wire logic rx_packet_ready,
  input wire logic ep0_halted
);
  logic wr_done;
  logic [4:0] nak_m_reg;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  // Write completing on lane 0
  assign wr_done = write && !waitrequest && byteenable[0];
  // Shadow of the programmed NAK limit
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      nak_m_reg <= 5'h00;
    end else if (wr_done && address == `UEP_ADDR_NAK_TMO) begin
      nak_m_reg <= writedata[4:0];
    end
  end
  property p_tally;
    read && waitrequest && address == `UEP_ADDR_EP0_TALLY |=> readdata == 32'($past(ep0_fifo_bytes));
  endproperty
  a_tally: assert property (p_tally) else $error("ep0 tally readback wrong");
  property p_speed;
    wr_done && address == `UEP_ADDR_EP0_SPEED |=> ep0_speed == $past(writedata[7:6]);
  endproperty
  a_speed: assert property (p_speed) else $error("ep0 speed not stored");
  property p_tx;
    wr_done && address == `UEP_ADDR_TX_SETUP |=> {tx_speed, tx_protocol, tx_target_ep} == $past(writedata[7:0]);
  endproperty
  a_tx: assert property (p_tx) else $error("tx setup not stored");
  property p_ep0_pkt;
    ep0_pkt_rx |=> ep0_rx_packet_ready;
  endproperty
  a_ep0_pkt: assert property (p_ep0_pkt) else $error("ep0 ready flag not set");
  property p_rx_pkt;
    rx_pkt_rx |=> rx_packet_ready;
  endproperty
  a_rx_pkt: assert property (p_rx_pkt) else $error("rx ready flag not set");
  property p_ro;
    write && address <= `UEP_ADDR_RX_TALLY |=> $stable({ep0_speed, tx_speed, tx_protocol, tx_target_ep});
  endproperty
  a_ro: assert property (p_ro) else $error("tally write changed state");
  property p_nak_off;
    nak_m_reg < 5'h02 |-> !$rose(ep0_halted);
  endproperty
  a_nak_off: assert property (p_nak_off) else $error("halt with time-out off");
  property p_halt;
    ep0_halted && !(wr_done && address == `UEP_ADDR_RDY_CTRL && writedata[2]) |=> ep0_halted;
  endproperty
  a_halt: assert property (p_halt) else $error("halt dropped without clear");
endmodule : uep_sva_chk
bind uep_ep_regs uep_sva_chk #(.EP0_CNT_W(EP0_CNT_W)) u_uep_sva_chk (
  .ref_clk, .srst, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
  .ep0_fifo_bytes, .ep0_pkt_rx, .rx_pkt_rx, .ep0_speed, .tx_speed, .tx_protocol, .tx_target_ep,
  .ep0_rx_packet_ready, .rx_packet_ready, .ep0_halted
);

// >>> bench/tb.sv
// Self-checking bench for the endpoint count/type register slice
`timescale 1ns/1ps
`include "uep_regs.svh"
module tb;
  // Bench-driven inputs
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0] byteenable = 4'h0;
  logic [6:0] ep0_fifo_bytes = 7'h00;
  logic [12:0] rx_fifo_bytes = 13'h0000;
  logic ep0_pkt_rx = 1'b0;
  logic rx_pkt_rx = 1'b0;
  logic host_mode = 1'b0;
  logic nak_mode = 1'b0;
  // Observed outputs and bench state
  logic [31:0] readdata, rd;
  logic waitrequest, frame_tick, ep0_nak_rx, ep0_resp_ok, ep0_rx_packet_ready, rx_packet_ready, ep0_halted, irq;
  logic [1:0] ep0_speed, tx_speed, tx_protocol;
  logic [3:0] tx_target_ep;
  logic [7:0] v;
  int n_mismatch = 0;
  int checks_done = 0;
  int nak_n = 0;
  // Clock
  always #50 ref_clk = ~ref_clk;
  // Design and remote target
  uep_ep_regs u_uep_ep_regs (
    .ref_clk, .srst, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
    .ep0_fifo_bytes, .rx_fifo_bytes, .ep0_pkt_rx, .rx_pkt_rx, .host_mode, .frame_tick, .ep0_nak_rx,
    .ep0_resp_ok, .ep0_speed, .tx_speed, .tx_protocol, .tx_target_ep, .ep0_rx_packet_ready,
    .rx_packet_ready, .ep0_halted, .irq
  );
  uep_usb_target u_uep_usb_target (.ref_clk, .srst, .nak_mode, .frame_tick, .ep0_nak_rx, .ep0_resp_ok);
  // Count NAKed frames until the halt
  always @(posedge ref_clk) begin
    if (ep0_nak_rx && !ep0_halted) begin
      nak_n++;
    end
  end
  // NAKed frames needed to exceed a limit of 2^(m-1)
  function automatic logic [31:0] f_halt_naks(input int m);
    return 32'((1 << (m - 1)) + 1);
  endfunction : f_halt_naks
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One Avalon transfer, held until waitrequest is seen low; only the watchdog ends a hang
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge ref_clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= {24'h000000, d};
    byteenable <= be;
    do begin
      @(posedge ref_clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  // Verdict
  task automatic finish_test();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  // Watchdog
  initial begin
    #2000000;
    n_mismatch++;
    finish_test();
  end
  // Main sequence
  initial begin
    void'($urandom(91186));
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    for (int a = 2; a < 6; a++) begin
      bus(1'b0, 4'(a), 8'h00, 4'hf);
      chk(rd, (a == 5) ? 32'h30 : 32'h0);
    end
    // Live tallies, full-scale first, writes to them ignored
    for (int i = 0; i < 8; i++) begin
      ep0_fifo_bytes <= (i == 0) ? 7'h7f : 7'($urandom);
      rx_fifo_bytes <= (i == 0) ? 13'h1fff : 13'($urandom);
      bus(1'b1, `UEP_ADDR_EP0_TALLY, 8'hff, 4'hf);
      bus(1'b0, `UEP_ADDR_EP0_TALLY, 8'h00, 4'hf);
      chk(rd, 32'(ep0_fifo_bytes));
      bus(1'b1, `UEP_ADDR_RX_TALLY, 8'hff, 4'hf);
      bus(1'b0, `UEP_ADDR_RX_TALLY, 8'h00, 4'hf);
      chk(rd, 32'(rx_fifo_bytes));
    end
    // Every speed and protocol code
    for (int i = 0; i < 4; i++) begin
      v = {i[1:0], i[1:0], 4'($urandom)};
      bus(1'b1, `UEP_ADDR_TX_SETUP, v, 4'hf);
      bus(1'b0, `UEP_ADDR_TX_SETUP, 8'h00, 4'hf);
      chk(rd, 32'(v));
      chk({tx_speed, tx_protocol, tx_target_ep}, 32'(v));
      bus(1'b1, `UEP_ADDR_EP0_SPEED, {i[1:0], 6'h3f}, 4'hf);
      bus(1'b0, `UEP_ADDR_EP0_SPEED, 8'h00, 4'hf);
      chk(rd, {24'h0, i[1:0], 6'h00});
      chk(ep0_speed, 32'(i[1:0]));
      bus(1'b0, `UEP_ADDR_RDY_CTRL, 8'h00, 4'hf);
      chk(rd, 32'({i == 0, i == 0, 4'h0}));
    end
    // Disabled lane and unmapped address
    bus(1'b1, `UEP_ADDR_TX_SETUP, 8'h00, 4'h0);
    bus(1'b0, `UEP_ADDR_TX_SETUP, 8'h00, 4'hf);
    chk(rd, 32'(v));
    bus(1'b1, 4'hf, 8'hff, 4'hf);
    bus(1'b0, 4'hf, 8'h00, 4'hf);
    chk(rd, 32'h0);
    // Packet arrival, interrupt raise, mask and clear
    bus(1'b1, `UEP_ADDR_INT_EN, 8'h03, 4'hf);
    ep0_pkt_rx <= 1'b1;
    rx_pkt_rx <= 1'b1;
    @(posedge ref_clk);
    ep0_pkt_rx <= 1'b0;
    rx_pkt_rx <= 1'b0;
    bus(1'b0, `UEP_ADDR_INT_STAT, 8'h00, 4'hf);
    chk(rd, 32'h3);
    chk({ep0_rx_packet_ready, rx_packet_ready, irq}, 32'h7);
    // Tallies keep following the FIFOs while the ready flags stand
    ep0_fifo_bytes <= 7'($urandom);
    rx_fifo_bytes <= 13'($urandom);
    bus(1'b0, `UEP_ADDR_EP0_TALLY, 8'h00, 4'hf);
    chk(rd, 32'(ep0_fifo_bytes));
    bus(1'b0, `UEP_ADDR_RX_TALLY, 8'h00, 4'hf);
    chk(rd, 32'(rx_fifo_bytes));
    bus(1'b1, `UEP_ADDR_INT_CLR, 8'h01, 4'hf);
    bus(1'b1, `UEP_ADDR_INT_EN, 8'h01, 4'hf);
    bus(1'b0, `UEP_ADDR_INT_STAT, 8'h00, 4'hf);
    chk({rd[7:0], irq}, 32'h4);
    bus(1'b1, `UEP_ADDR_INT_CLR, 8'h02, 4'hf);
    bus(1'b1, `UEP_ADDR_RDY_CTRL, 8'h03, 4'hf);
    bus(1'b0, `UEP_ADDR_RDY_CTRL, 8'h00, 4'hf);
    chk(rd, 32'h0);
    // NAK time-out with short limits
    host_mode <= 1'b1;
    bus(1'b1, `UEP_ADDR_INT_EN, 8'h04, 4'hf);
    for (int m = 2; m < 4; m++) begin
      bus(1'b1, `UEP_ADDR_NAK_TMO, {3'h7, 5'(m)}, 4'hf);
      bus(1'b0, `UEP_ADDR_NAK_TMO, 8'h00, 4'hf);
      chk(rd, 32'(m));
      nak_n = 0;
      nak_mode <= 1'b1;
      for (int k = 0; k < 200 && ep0_halted !== 1'b1; k++) begin
        @(posedge ref_clk);
      end
      nak_mode <= 1'b0;
      chk(nak_n, f_halt_naks(m));
      chk({ep0_halted, irq}, 32'h3);
      bus(1'b1, `UEP_ADDR_RDY_CTRL, 8'h04, 4'hf);
      bus(1'b1, `UEP_ADDR_INT_CLR, 8'h04, 4'hf);
    end
    // Limits 0 and 1 never halt, nor does a valid limit outside host mode
    for (int m = 0; m < 3; m++) begin
      host_mode <= (m < 2);
      bus(1'b1, `UEP_ADDR_NAK_TMO, 8'(m), 4'hf);
      nak_mode <= 1'b1;
      repeat (200) @(posedge ref_clk);
      nak_mode <= 1'b0;
      chk(ep0_halted, 32'h0);
    end
    finish_test();
  end
endmodule : tb
